/* capture_input_pkg.sv */
// constants and carrier types for the input-capture front end
`default_nettype none

package capture_input_pkg;

  // register byte offsets on the wishbone bus
  localparam logic [3:0] MODE_OFFSET = 4'h0;
  localparam logic [3:0] CTRL_OFFSET = 4'h4;
  localparam logic [3:0] STATUS_OFFSET = 4'h8;

  // reset values
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  // mode register field positions
  localparam int CH2_FILTER_MSB = 15;
  localparam int CH2_FILTER_LSB = 12;
  localparam int CH2_DIVIDER_MSB = 11;
  localparam int CH2_DIVIDER_LSB = 10;
  localparam int CH2_DIR_MSB = 9;
  localparam int CH2_DIR_LSB = 8;
  localparam int CH1_FILTER_MSB = 7;
  localparam int CH1_FILTER_LSB = 4;
  localparam int CH1_DIVIDER_MSB = 3;
  localparam int CH1_DIVIDER_LSB = 2;
  localparam int CH1_DIR_MSB = 1;
  localparam int CH1_DIR_LSB = 0;

  // control register bit positions
  localparam int CTRL_CH1_EN_BIT = 0;
  localparam int CTRL_CH2_EN_BIT = 1;
  localparam int CTRL_TRIG_INT_BIT = 2;

  // direction select codes
  localparam logic [1:0] DIR_OUTPUT = 2'h0;
  localparam logic [1:0] DIR_OWN_INPUT = 2'h1;
  localparam logic [1:0] DIR_NEIGHBOUR = 2'h2;
  localparam logic [1:0] DIR_TRIGGER = 2'h3;

  // filter lengths in samples
  localparam logic [3:0] FILT_N2 = 4'h2;
  localparam logic [3:0] FILT_N4 = 4'h4;
  localparam logic [3:0] FILT_N5 = 4'h5;
  localparam logic [3:0] FILT_N6 = 4'h6;
  localparam logic [3:0] FILT_N8 = 4'h8;

  // sampling clock division, as a power of two
  localparam logic [2:0] RATE_DIV1 = 3'h0;
  localparam logic [2:0] RATE_DIV2 = 3'h1;
  localparam logic [2:0] RATE_DIV4 = 3'h2;
  localparam logic [2:0] RATE_DIV8 = 3'h3;
  localparam logic [2:0] RATE_DIV16 = 3'h4;
  localparam logic [2:0] RATE_DIV32 = 3'h5;

  // default division from kernel clock to dead-time/sampling clock
  localparam int DTS_DIV_DEFAULT = 1;

  // one channel's configuration byte
  typedef struct packed {
    logic [3:0] filter;
    logic [1:0] divider;
    logic [1:0] dir;
  } chan_cfg_type;

  // the whole mode register, channel 2 in the upper byte
  typedef struct packed {
    chan_cfg_type ch2;
    chan_cfg_type ch1;
  } mode_reg_type;

endpackage

`default_nettype wire

/* capture_input_conditioning.sv */
// input routing, digital filter and event prescaler for capture channels 1 and 2
// Behaviour
// - channel-2 direction: 00 output, 01 own pin, 10 input one, 11 trigger
// - channel-2 trigger route works only while an internal trigger is selected
// - channel-2 direction writes take effect only while channel 2 is disabled
// - channel-1 filter code sets sample rate and length; output moves after N samples
// - filter code 0000 means no filter, sampling at the dead-time clock
// - codes 0001..0011 sample at kernel clock with N of 2, 4, 8
// - codes 0100..1001 sample at dts/2, /4, /8 with N of 6 then 8
// - codes 1010..1111 sample at dts/16 and /32 with N of 5, 6, 8
// - channel-1 prescaler captures every rising edge, or every 2, 4, 8 events
// - channel-1 prescaler clears while channel 1 is disabled
// - channel-1 direction: 00 output, 01 input one, 10 input two, 11 trigger
// - channel-1 trigger route works only while an internal trigger is selected
// - channel-1 direction writes take effect only while channel 1 is disabled
// - channel-2 filter field sits at bits 15 to 12
// - channel-2 prescaler field sits at bits 11 to 10
`timescale 1ns/100ps
`default_nettype none

module capture_input_conditioning
  import capture_input_pkg::*;
#(
  parameter int DTS_DIV = DTS_DIV_DEFAULT
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic timer_input_one_i,
  input wire logic timer_input_two_i,
  input wire logic trigger_controller_signal_i,
  output logic chan1_capture_path_o,
  output logic chan2_capture_path_o,
  output logic chan1_capture_o,
  output logic chan2_capture_o,
  output logic chan1_is_input_o,
  output logic chan2_is_input_o
);

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // filter length per code
  function automatic logic [3:0] filter_len(input logic [3:0] code);
    case (code)
      4'h1: filter_len = FILT_N2;
      4'h2: filter_len = FILT_N4;
      4'h4, 4'h6, 4'h8, 4'hb, 4'he: filter_len = FILT_N6;
      4'ha, 4'hd: filter_len = FILT_N5;
      4'h0: filter_len = 4'h1;
      default: filter_len = FILT_N8;
    endcase
  endfunction

  // sampling division of the dead-time clock per code
  function automatic logic [2:0] filter_rate(input logic [3:0] code);
    case (code)
      4'h4, 4'h5: filter_rate = RATE_DIV2;
      4'h6, 4'h7: filter_rate = RATE_DIV4;
      4'h8, 4'h9: filter_rate = RATE_DIV8;
      4'ha, 4'hb, 4'hc: filter_rate = RATE_DIV16;
      4'hd, 4'he, 4'hf: filter_rate = RATE_DIV32;
      default: filter_rate = RATE_DIV1;
    endcase
  endfunction

  // input selection for one channel
  function automatic logic route(input logic [1:0] dir, input logic own, input logic nb,
                                 input logic trigger_controller_signal, input logic trig_int);
    case (dir)
      DIR_OWN_INPUT: route = own;
      DIR_NEIGHBOUR: route = nb;
      DIR_TRIGGER: route = trigger_controller_signal & trig_int;
      default: route = 1'b0;
    endcase
  endfunction

  mode_reg_type mode;
  logic [2:0] ctrl;
  chan_cfg_type cfg [2];
  logic [1:0] en;
  logic trig_int;
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [1:0] pin_level;
  logic [$clog2(DTS_DIV + 1)-1:0] dts_cnt;
  logic dts_tick;
  logic [4:0] rate_cnt;
  logic [1:0] sample_tick;
  logic [1:0] filt;
  logic [3:0] fcnt [2];
  logic [1:0] path;
  logic [1:0] path_prev;
  logic [1:0] event_seen;
  logic [2:0] presc_cnt [2];
  logic [1:0] capture;
  logic bus_req;
  logic mode_write;
  logic ctrl_write;

  assign cfg[0] = mode.ch1;
  assign cfg[1] = mode.ch2;
  assign en = {ctrl[CTRL_CH2_EN_BIT], ctrl[CTRL_CH1_EN_BIT]};
  assign trig_int = ctrl[CTRL_TRIG_INT_BIT];
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign mode_write = bus_req && wb_we_i && wb_adr_i == MODE_OFFSET;
  assign ctrl_write = bus_req && wb_we_i && wb_adr_i == CTRL_OFFSET;

  // wishbone answer one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // read data, unmapped offsets read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req && !wb_we_i) begin
      case (wb_adr_i)
        MODE_OFFSET: wb_dat_o <= {16'h0000, mode};
        CTRL_OFFSET: wb_dat_o <= {29'h0000_0000, ctrl};
        STATUS_OFFSET: wb_dat_o <= {24'h00_0000, capture, path, filt, pin_level};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // mode register, byte lanes per channel
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode <= MODE_RESET;
    end else if (mode_write) begin
      if (wb_sel_i[0]) begin
        mode.ch1.filter <= wb_dat_i[CH1_FILTER_MSB:CH1_FILTER_LSB];
        mode.ch1.divider <= wb_dat_i[CH1_DIVIDER_MSB:CH1_DIVIDER_LSB];
        if (!en[0]) begin
          mode.ch1.dir <= wb_dat_i[CH1_DIR_MSB:CH1_DIR_LSB];
        end
      end
      if (wb_sel_i[1]) begin
        mode.ch2.filter <= wb_dat_i[CH2_FILTER_MSB:CH2_FILTER_LSB];
        mode.ch2.divider <= wb_dat_i[CH2_DIVIDER_MSB:CH2_DIVIDER_LSB];
        if (!en[1]) begin
          mode.ch2.dir <= wb_dat_i[CH2_DIR_MSB:CH2_DIR_LSB];
        end
      end
    end
  end

  // control register: enables and internal trigger select
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= CTRL_RESET;
    end else if (ctrl_write && wb_sel_i[0]) begin
      ctrl <= wb_dat_i[2:0];
    end
  end

  // three-stage pin synchronisers, level taken when stages two and three agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
      pin_level <= 2'h0;
    end else begin
      sync1 <= {sync1[1:0], timer_input_one_i};
      sync2 <= {sync2[1:0], timer_input_two_i};
      if (sync1[1] == sync1[2]) begin
        pin_level[0] <= sync1[2];
      end
      if (sync2[1] == sync2[2]) begin
        pin_level[1] <= sync2[2];
      end
    end
  end

  // dead-time clock tick and rate counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dts_cnt <= '0;
      rate_cnt <= 5'h00;
    end else begin
      if (dts_tick) begin
        rate_cnt <= 5'(rate_cnt + 5'h01);
      end
      if (int'(dts_cnt) == DTS_DIV - 1) begin
        dts_cnt <= '0;
      end else begin
        dts_cnt <= ($bits(dts_cnt))'(dts_cnt + 1'b1);
      end
    end
  end

  assign dts_tick = dts_cnt == '0;

  // sampling strobe per channel
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      if (cfg[c].filter inside {4'h1, 4'h2, 4'h3}) begin
        sample_tick[c] = 1'b1;
      end else begin
        sample_tick[c] = dts_tick &&
          ((rate_cnt & 5'((6'h01 << filter_rate(cfg[c].filter)) - 6'h01)) == 5'h00);
      end
    end
  end

  // digital filter, one per timer input
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      filt <= 2'h0;
      fcnt[0] <= 4'h0;
      fcnt[1] <= 4'h0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (sample_tick[c]) begin
          if (cfg[c].filter == 4'h0) begin
            filt[c] <= pin_level[c];
            fcnt[c] <= 4'h0;
          end else if (pin_level[c] == filt[c]) begin
            fcnt[c] <= 4'h0;
          end else if (4'(fcnt[c] + 4'h1) >= filter_len(cfg[c].filter)) begin
            filt[c] <= pin_level[c];
            fcnt[c] <= 4'h0;
          end else begin
            fcnt[c] <= 4'(fcnt[c] + 4'h1);
          end
        end
      end
    end
  end

  // capture path routing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      path <= 2'h0;
      path_prev <= 2'h0;
    end else begin
      path[0] <= route(cfg[0].dir, filt[0], filt[1], trigger_controller_signal_i, trig_int);
      path[1] <= route(cfg[1].dir, filt[1], filt[0], trigger_controller_signal_i, trig_int);
      path_prev <= path;
    end
  end

  assign event_seen = path & ~path_prev;

  // event prescaler per channel
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      presc_cnt[0] <= 3'h0;
      presc_cnt[1] <= 3'h0;
      capture <= 2'h0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        capture[c] <= 1'b0;
        if (!en[c] || cfg[c].dir == DIR_OUTPUT) begin
          presc_cnt[c] <= 3'h0;
        // capture once per 1, 2, 4 or 8 events
        end else if (event_seen[c]) begin
          if (presc_cnt[c] >= 3'((4'h1 << cfg[c].divider) - 4'h1)) begin
            presc_cnt[c] <= 3'h0;
            capture[c] <= 1'b1;
          end else begin
            presc_cnt[c] <= 3'(presc_cnt[c] + 3'h1);
          end
        end
      end
    end
  end

  assign chan1_capture_path_o = path[0];
  assign chan2_capture_path_o = path[1];
  assign chan1_capture_o = capture[0];
  assign chan2_capture_o = capture[1];
  assign chan1_is_input_o = cfg[0].dir != DIR_OUTPUT;
  assign chan2_is_input_o = cfg[1].dir != DIR_OUTPUT;

  sequence s_mode_write_low;
    mode_write && wb_sel_i[0];
  endsequence

  sequence s_mode_write_high;
    mode_write && wb_sel_i[1];
  endsequence

  a_dir1_locked: assert property (s_mode_write_low and en[0] |=> $stable(mode.ch1.dir))
    else $error("channel-1 direction changed while enabled");

  a_dir2_locked: assert property (s_mode_write_high and en[1] |=> $stable(mode.ch2.dir))
    else $error("channel-2 direction changed while enabled");

  a_trc_gate_one: assert property (
    cfg[0].dir == DIR_TRIGGER && !trig_int |=> !path[0])
    else $error("channel-1 trigger route active without internal trigger");

  a_trc_gate_two: assert property (
    cfg[1].dir == DIR_TRIGGER && !trig_int |=> !path[1])
    else $error("channel-2 trigger route active without internal trigger");

  a_route_one: assert property (
    cfg[0].dir == DIR_NEIGHBOUR |=> path[0] == $past(filt[1]))
    else $error("channel-1 path not taken from input two");

  a_route_two: assert property (
    cfg[1].dir == DIR_NEIGHBOUR |=> path[1] == $past(filt[0]))
    else $error("channel-2 path not taken from input one");

  a_nofilter_follow: assert property (
    cfg[0].filter == 4'h0 && dts_tick |=> filt[0] == $past(pin_level[0]))
    else $error("unfiltered channel did not follow its input");

  a_filter_count: assert property (
    cfg[0].filter != 4'h0 && $stable(cfg[0].filter) && $changed(filt[0])
      |-> 4'($past(fcnt[0]) + 4'h1) == filter_len(cfg[0].filter))
    else $error("filter output moved before N samples");

  a_filter_two: assert property (
    cfg[0].filter == 4'h1 && pin_level[0] != filt[0] ##1
      (cfg[0].filter == 4'h1 && pin_level[0] != filt[0] && $stable(pin_level[0]))
      |=> filt[0] == $past(pin_level[0]))
    else $error("two-sample filter did not switch after two samples");

  a_presc_clear: assert property (!en[0] |=> presc_cnt[0] == 3'h0 && !capture[0])
    else $error("channel-1 prescaler not cleared while disabled");

  a_presc_every: assert property (
    en[0] && cfg[0].dir != DIR_OUTPUT && cfg[0].divider == 2'h0 && event_seen[0]
      |=> capture[0])
    else $error("undivided capture missed an event");

endmodule

`default_nettype wire

/* pin_source.sv */
// timer input pins and internal trigger source model
`timescale 1ns/100ps
`default_nettype none

module pin_source (
  input wire logic clk_i,
  output var logic one_o,
  output var logic two_o,
  output var logic trig_o
);
  initial begin
    one_o = 1'b0;
    two_o = 1'b0;
    trig_o = 1'b0;
  end

  // levels change just after a kernel clock edge
  task automatic drive(input logic a, input logic b, input logic t);
    @(posedge clk_i);
    one_o <= a;
    two_o <= b;
    trig_o <= t;
  endtask
endmodule

`default_nettype wire

/* tb_capture_input_conditioning.sv */
// self-checking bench for the capture input front end
`timescale 1ns/100ps
`default_nettype none

module tb_capture_input_conditioning;
  import capture_input_pkg::*;
  localparam int DIV = 2;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] rv;
  logic ack, one, two, trig, p1, p2, c1, c2, in1, in2;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int cap1 = 0;
  int cap2 = 0;
  int ntab[16] = '{1, 2, 4, 8, 6, 8, 6, 8, 6, 8, 5, 6, 8, 5, 6, 8};
  int stab[16] = '{0, 0, 0, 0, 1, 1, 2, 2, 3, 3, 4, 4, 4, 5, 5, 5};

  always #20 clk_i = ~clk_i;

  pin_source src (.clk_i(clk_i), .one_o(one), .two_o(two), .trig_o(trig));

  capture_input_conditioning #(.DTS_DIV(DIV)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .timer_input_one_i(one), .timer_input_two_i(two), .trigger_controller_signal_i(trig),
    .chan1_capture_path_o(p1), .chan2_capture_path_o(p2), .chan1_capture_o(c1),
    .chan2_capture_o(c2), .chan1_is_input_o(in1), .chan2_is_input_o(in2)
  );

  task automatic close_out();
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (c1 === 1'b1) cap1 <= cap1 + 1;
    if (c2 === 1'b1) cap2 <= cap2 + 1;
    if (cycles == 40000) begin
      bad_count++;
      close_out();
    end
  end

  task automatic check1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic check32(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %0h expected %0h", $time, got, exp);
    end
  endtask

  // classic single wishbone cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rv = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wait_c(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic reg_reset();
    wb(1'b0, MODE_OFFSET, 32'h0);
    check32(rv, {16'h0, MODE_RESET});
    wb(1'b0, CTRL_OFFSET, 32'h0);
    check32(rv, {29'h0, CTRL_RESET});
    wb(1'b1, 4'hc, 32'hffff);
    wb(1'b0, 4'hc, 32'h0);
    check32(rv, 32'h0);
  endtask

  task automatic routing();
    logic e1, e2;
    for (int p = 0; p < 2; p++) begin
      src.drive(p[0], ~p[0], ~p[0]);
      for (int d = 0; d < 4; d++) begin
        for (int t = 0; t < 2; t++) begin
          wb(1'b1, CTRL_OFFSET, {29'h0, t[0], 2'h0});
          wb(1'b1, MODE_OFFSET, {16'h0, 6'h0, d[1:0], 6'h0, d[1:0]});
          wait_c(12);
          e1 = (d == 1) ? p[0] : (d == 2) ? ~p[0] : t[0] & ~p[0];
          e2 = (d == 1) ? ~p[0] : (d == 2) ? p[0] : t[0] & ~p[0];
          check1(in1, d != 0);
          check1(in2, d != 0);
          if (d != 0) begin
            check1(p1, e1);
            check1(p2, e2);
          end
        end
      end
      wb(1'b0, STATUS_OFFSET, 32'h0);
      check32(rv & 32'h3, {30'h0, ~p[0], p[0]});
    end
  endtask

  task automatic dir_lock();
    wb(1'b1, CTRL_OFFSET, 32'h0);
    wb(1'b1, MODE_OFFSET, 32'h0101);
    wb(1'b1, CTRL_OFFSET, 32'h3);
    wb(1'b1, MODE_OFFSET, 32'h1e2e);
    wb(1'b0, MODE_OFFSET, 32'h0);
    check32(rv, 32'h1d2d);
    wb(1'b1, CTRL_OFFSET, 32'h0);
    wb(1'b1, MODE_OFFSET, 32'h0202);
    wb(1'b0, MODE_OFFSET, 32'h0);
    check32(rv, 32'h0202);
  endtask

  task automatic filter();
    int n, p, l, w;
    for (int c = 0; c < 16; c++) begin
      n = ntab[c];
      p = (c > 0 && c < 4) ? 1 : DIV << stab[c];
      l = (n - 2) * p;
      w = n * p + 8;
      wb(1'b1, MODE_OFFSET, {16'h0, c[3:0], 4'h1, c[3:0], 4'h1});
      if (l > 0) begin
        src.drive(1'b1, 1'b1, 1'b0);
        wait_c(l - 1);
        src.drive(1'b0, 1'b0, 1'b0);
        wait_c(w + l);
        check1(p1, 1'b0);
        check1(p2, 1'b0);
      end
      src.drive(1'b1, 1'b1, 1'b0);
      wait_c(w);
      check1(p1, 1'b1);
      check1(p2, 1'b1);
      src.drive(1'b0, 1'b0, 1'b0);
      wait_c(w);
    end
  endtask

  task automatic edges(input int k);
    repeat (k) begin
      src.drive(1'b1, 1'b0, 1'b0);
      wait_c(10);
      src.drive(1'b0, 1'b0, 1'b0);
      wait_c(10);
    end
  endtask

  task automatic prescale();
    int b1, b2;
    for (int k = 0; k < 4; k++) begin
      wb(1'b1, CTRL_OFFSET, 32'h0);
      wb(1'b1, MODE_OFFSET, {16'h0, 4'h0, k[1:0], 2'h2, 4'h0, k[1:0], 2'h1});
      wb(1'b1, CTRL_OFFSET, 32'h3);
      b1 = cap1;
      b2 = cap2;
      edges(8);
      check32(32'(cap1 - b1), 32'(8 >> k));
      check32(32'(cap2 - b2), 32'(8 >> k));
    end
    wb(1'b1, CTRL_OFFSET, 32'h0);
    wb(1'b1, MODE_OFFSET, 32'h0a09);
    wb(1'b1, CTRL_OFFSET, 32'h3);
    b1 = cap1;
    b2 = cap2;
    edges(3);
    wb(1'b1, CTRL_OFFSET, 32'h0);
    wb(1'b1, CTRL_OFFSET, 32'h3);
    edges(1);
    check32(32'(cap1 - b1), 32'h0);
    check32(32'(cap2 - b2), 32'h0);
    edges(3);
    check32(32'(cap1 - b1), 32'h1);
  endtask

  task automatic mid_reset();
    wb(1'b1, CTRL_OFFSET, 32'h0);
    wb(1'b1, MODE_OFFSET, 32'h1111);
    wb(1'b1, CTRL_OFFSET, 32'h7);
    check1(in1, 1'b1);
    @(posedge clk_i);
    rst_i <= 1'b1;
    wait_c(2);
    rst_i <= 1'b0;
    check1(in1, 1'b0);
    check1(in2, 1'b0);
    wb(1'b0, CTRL_OFFSET, 32'h0);
    check32(rv, {29'h0, CTRL_RESET});
    wb(1'b0, MODE_OFFSET, 32'h0);
    check32(rv, {16'h0, MODE_RESET});
    wb(1'b1, MODE_OFFSET, 32'h0202);
    wb(1'b0, MODE_OFFSET, 32'h0);
    check32(rv, 32'h0202);
  endtask

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    reg_reset();
    routing();
    dir_lock();
    filter();
    prescale();
    mid_reset();
    close_out();
  end
endmodule

`default_nettype wire
